// [hw/ssbg_pkg.sv]
// package: register map, field layout and constants of the serial status and baud generator
package ssbg_pkg;
  // word offsets on the bus
  localparam logic [3:0] SSBG_OFS_STATUS  = 4'h0;
  localparam logic [3:0] SSBG_OFS_DIVIDER = 4'h4;
  localparam logic [3:0] SSBG_OFS_MODE    = 4'h8;
  localparam logic [3:0] SSBG_OFS_IRQ_ST  = 4'hC;
  localparam int          SSBG_ADR_W       = 4;
  // status field positions
  localparam int SSBG_B_TDE  = 7;
  localparam int SSBG_B_TRANSMIT_END_FLAG = 2;
  localparam int SSBG_B_RMPB = 1;
  localparam int SSBG_B_TMPB = 0;
  // mode register field positions (own layout)
  localparam int SSBG_B_TE   = 0;
  localparam int SSBG_B_RE   = 1;
  localparam int SSBG_B_MP   = 2;
  localparam int SSBG_B_SYNC = 3;
  localparam int SSBG_B_CKS  = 4;
  localparam int SSBG_B_SUB  = 6;
  localparam int SSBG_B_MASK = 8;
  // reset values
  localparam logic [7:0] SSBG_DIV_RST  = 8'hFF;
  localparam logic [7:0] SSBG_ZERO8    = 8'h00;
  // prescaler terminal counts
  localparam logic [5:0] SSBG_PRE_16   = 6'h0F;
  localparam logic [5:0] SSBG_PRE_64   = 6'h3F;
  localparam logic [5:0] SSBG_PRE_SUB  = 6'h01;
  // interrupt event bits
  localparam int SSBG_EV_TDE  = 0;
  localparam int SSBG_EV_TRANSMIT_END_FLAG = 1;
  localparam int SSBG_EV_RX   = 2;
  localparam int SSBG_EV_N    = 3;

  typedef enum logic [1:0] {
    SSBG_CK_SYS   = 2'h0,
    SSBG_CK_SUB   = 2'h1,
    SSBG_CK_DIV16 = 2'h2,
    SSBG_CK_DIV64 = 2'h3
  } ssbg_cks_e;

  // transfer events coming from the shift logic
  typedef struct packed {
    logic tx_load;     // holding register moved into shift register
    logic tx_last;     // final bit of a character left the shifter
    logic rx_done;     // character received
    logic rx_mpb;      // received multiprocessor bit
  } ssbg_xfer_s;
endpackage : ssbg_pkg

// [hw/ssbg_baud.sv]
// baud generator: prescaler plus divider down-counter
`timescale 1ns/10ps
module ssbg_baud
  import ssbg_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // configuration
  input  wire logic [7:0] divider,
  input  wire ssbg_cks_e  cks,
  input  wire logic       sub_tick,
  input  wire logic       sub_half,
  // output
  output logic            baud_tick
);
  logic [5:0] pre_r;
  logic [7:0] cnt_r;
  logic [5:0] pre_top;
  logic       pre_hit;
  logic       src_tick;
  logic       cnt_zero;

  // prescaler terminal count follows clock select
  assign pre_top  = (cks == SSBG_CK_DIV16) ? SSBG_PRE_16 :
                    (cks == SSBG_CK_DIV64) ? SSBG_PRE_64 :
                    (sub_half ? SSBG_PRE_SUB : 6'h00);
  assign pre_hit  = (pre_r >= pre_top);
  assign src_tick = (cks == SSBG_CK_SYS) ? 1'b1 :
                    (cks == SSBG_CK_SUB) ? (sub_tick && (pre_hit || !sub_half)) :
                    pre_hit;
  assign cnt_zero = (cnt_r == SSBG_ZERO8);

  // prescaler counts system clocks, or subclock ticks when subclock selected
  always_ff @(posedge clk) begin
    if (rst || (pre_hit && (cks != SSBG_CK_SUB || sub_tick))) begin
      pre_r <= 6'h00;
    end else if (cks != SSBG_CK_SUB || sub_tick) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  // down-counter reloads at terminal count, so new values apply next period
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r     <= SSBG_DIV_RST;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= src_tick && cnt_zero;
      if (src_tick) begin
        cnt_r <= cnt_zero ? divider : cnt_r - 8'h01;
      end
    end
  end
endmodule : ssbg_baud

// [hw/ssbg_top.sv]
// serial status flags, bit rate divider and baud generator with wishbone slave
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
module ssbg_top
  import ssbg_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // power-mode entry (standby, module standby, watch)
  input  wire logic       low_power,
  // subclock tick, a pin-rate pulse from another domain
  input  wire logic       sub_clk_pin,
  // wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  // shift logic side
  input  wire ssbg_xfer_s xfer,
  output logic            baud_tick,
  output logic            tx_mpb_out,
  output logic            tx_enable,
  output logic            rx_enable,
  // interrupt
  output logic            irq
);
  logic [7:0]  div_r;
  logic [7:0]  mode_r;
  logic [2:0]  mask_r;
  logic [2:0]  ist_r;
  logic        tde_r, transmit_end_flag_r, rmpb_r, tmpb_r;
  logic        tde_seen_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        irq_r;
  logic        te_q_r;
  logic [2:0]  sub_sync_r;
  logic        mpb_r;

  wire         init      = rst || low_power;
  wire         req       = wb_cyc_i && wb_stb_i && !ack_r;
  wire         wr        = req && wb_we_i && wb_sel_i[0];
  wire         rd        = req && !wb_we_i;
  wire         hit_st    = (wb_adr_i == SSBG_OFS_STATUS);
  wire         hit_div   = (wb_adr_i == SSBG_OFS_DIVIDER);
  wire         hit_mode  = (wb_adr_i == SSBG_OFS_MODE);
  wire         hit_ist   = (wb_adr_i == SSBG_OFS_IRQ_ST);
  wire         wr_st     = wr && hit_st;
  wire         wr_tdr    = wr && hit_st && wb_sel_i[1];
  wire         te        = mode_r[SSBG_B_TE];
  wire         re        = mode_r[SSBG_B_RE];
  wire         mp        = mode_r[SSBG_B_MP];
  wire         sync_m    = mode_r[SSBG_B_SYNC];
  wire         te_fall   = te_q_r && !te;
  wire         sub_tick  = sub_sync_r[1] && !sub_sync_r[2];
  wire [7:0]   status    = {tde_r, 4'h0, transmit_end_flag_r, rmpb_r, tmpb_r};
  wire         clr_tde   = wr_st && !wb_dat_i[SSBG_B_TDE] && tde_seen_r;
  wire         set_tde   = te_fall || xfer.tx_load;
  wire         set_transmit_end_flag  = te_fall || (xfer.tx_last && tde_r);
  wire         clr_transmit_end_flag  = clr_tde || wr_tdr;
  wire         rx_cap    = xfer.rx_done && re && mp && !sync_m;
  wire [2:0]   ev;
  wire [31:0]  rd_mux;

  // read mux; unmapped addresses read zero and still ack
  assign rd_mux = hit_st   ? {24'h000000, status} :
                  hit_div  ? {24'h000000, div_r} :
                  hit_mode ? {21'h000000, mask_r, mode_r} :
                  hit_ist  ? {29'h00000000, ist_r} : 32'h00000000;

  assign ev[SSBG_EV_TDE]  = set_tde;
  assign ev[SSBG_EV_TRANSMIT_END_FLAG] = set_transmit_end_flag;
  assign ev[SSBG_EV_RX]   = rx_cap;

  // bus slave answers one cycle after the request, ack lasts one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req;
      dat_r <= rd ? rd_mux : 32'h00000000;
    end
  end

  // divider register: all ones on reset and low-power entry, otherwise freely written
  always_ff @(posedge clk) begin
    if (init) begin
      div_r <= SSBG_DIV_RST;
    end else if (wr && hit_div) begin
      div_r <= wb_dat_i[7:0];
    end
  end

  // mode and mask registers
  always_ff @(posedge clk) begin
    if (init) begin
      mode_r <= SSBG_ZERO8;
      mask_r <= 3'h0;
    end else if (wr && hit_mode) begin
      mode_r <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        mask_r <= wb_dat_i[SSBG_B_MASK +: SSBG_EV_N];
      end
    end
  end

  // remember that holding-empty was read as one, needed before a zero write clears it
  always_ff @(posedge clk) begin
    if (init || clr_tde) begin
      tde_seen_r <= 1'b0;
    end else if (rd && hit_st && tde_r) begin
      tde_seen_r <= 1'b1;
    end
  end

  // holding-empty flag; set wins over clear
  always_ff @(posedge clk) begin
    if (init) begin
      tde_r <= 1'b1;
    end else if (set_tde) begin
      tde_r <= 1'b1;
    end else if (clr_tde || wr_tdr) begin
      tde_r <= 1'b0;
    end
  end

  // transmit end flag; set wins over clear
  always_ff @(posedge clk) begin
    if (init) begin
      transmit_end_flag_r <= 1'b1;
    end else if (set_transmit_end_flag) begin
      transmit_end_flag_r <= 1'b1;
    end else if (clr_transmit_end_flag) begin
      transmit_end_flag_r <= 1'b0;
    end
  end

  // received multiprocessor bit: captured only on multiprocessor receive, never written
  always_ff @(posedge clk) begin
    if (init) begin
      rmpb_r <= 1'b0;
    end else if (rx_cap) begin
      rmpb_r <= xfer.rx_mpb;
    end
  end

  // transmit multiprocessor bit control field
  always_ff @(posedge clk) begin
    if (init) begin
      tmpb_r <= 1'b0;
    end else if (wr_st) begin
      tmpb_r <= wb_dat_i[SSBG_B_TMPB];
    end
  end

  // appended bit only meaningful in async multiprocessor transmission
  assign mpb_r = te && mp && !sync_m && tmpb_r;

  // output registers and transmit-enable edge tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      te_q_r     <= 1'b0;
      tx_mpb_out <= 1'b0;
      tx_enable  <= 1'b0;
      rx_enable  <= 1'b0;
    end else begin
      te_q_r     <= te;
      tx_mpb_out <= mpb_r;
      tx_enable  <= te;
      rx_enable  <= re;
    end
  end

  // subclock pin synchroniser, third stage only for edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      sub_sync_r <= 3'h0;
    end else begin
      sub_sync_r <= {sub_sync_r[1:0], sub_clk_pin};
    end
  end

  // sticky interrupt status, write one to clear, event wins
  always_ff @(posedge clk) begin
    if (init) begin
      ist_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= ev | (ist_r & ~((wr && hit_ist) ? wb_dat_i[2:0] : 3'h0));
      irq_r <= |(ist_r & mask_r);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq      = irq_r;

  // baud generator on selected prescaled clock
  ssbg_baud u_baud (
    .clk       (clk),
    .rst       (init),
    .divider   (div_r),
    .cks       (ssbg_cks_e'(mode_r[SSBG_B_CKS +: 2])),
    .sub_tick  (sub_tick),
    .sub_half  (!mode_r[SSBG_B_SUB]),
    .baud_tick (baud_tick)
  );

  // assertions
  a_transmit_end_flag_set: assert property (@(posedge clk) disable iff (rst)
    set_transmit_end_flag |=> transmit_end_flag_r) else $error("transmit end not set");
  a_transmit_end_flag_clr: assert property (@(posedge clk) disable iff (rst)
    (wr_tdr && !set_transmit_end_flag && !low_power) |=> !transmit_end_flag_r) else $error("transmit_end_flag not cleared");
  a_rmpb_hold: assert property (@(posedge clk) disable iff (rst)
    (!rx_cap && !low_power) |=> $stable(rmpb_r)) else $error("rmpb changed");
  a_rmpb_cap: assert property (@(posedge clk) disable iff (rst)
    (rx_cap && !low_power) |=> rmpb_r == $past(xfer.rx_mpb)) else $error("rmpb");
  a_mpb_sync: assert property (@(posedge clk) disable iff (rst)
    sync_m |=> !tx_mpb_out) else $error("mpb sent in sync mode");
  a_div_init: assert property (@(posedge clk)
    init |=> div_r == SSBG_DIV_RST) else $error("divider not all ones");
  a_div_write: assert property (@(posedge clk) disable iff (rst)
    (wr && hit_div && !low_power) |=> div_r == $past(wb_dat_i[7:0])) else $error("div wr");
  a_tde_set: assert property (@(posedge clk) disable iff (rst)
    xfer.tx_load |=> tde_r) else $error("tde not set");
  a_tde_clr: assert property (@(posedge clk) disable iff (rst)
    (clr_tde && !set_tde && !low_power) |=> !tde_r) else $error("tde not cleared");
  a_tde_tefall: assert property (@(posedge clk) disable iff (rst)
    te_fall |=> (tde_r && transmit_end_flag_r)) else $error("flags not set on disable");
  a_mpb_send: assert property (@(posedge clk) disable iff (rst)
    (te && mp && !sync_m && tmpb_r) |=> tx_mpb_out) else $error("mpb not sent");
  a_mpb_nomp: assert property (@(posedge clk) disable iff (rst)
    !mp |=> !tx_mpb_out) else $error("mpb sent without multiproc");
  a_rmpb_keep: assert property (@(posedge clk) disable iff (rst)
    (!re && mp && !low_power) |=> $stable(rmpb_r)) else $error("rmpb lost");
  a_div_hold: assert property (@(posedge clk) disable iff (rst)
    (!init && !(wr && hit_div)) |=> $stable(div_r)) else $error("divider moved");
  // the subclock path and the low-power entry are the rarely reached corners
  c_sub: cover property (@(posedge clk) (mode_r[SSBG_B_CKS +: 2] == SSBG_CK_SUB) && baud_tick);
  c_lowpower: cover property (@(posedge clk) low_power);
  c_transmit_end_flag: cover property (@(posedge clk) set_transmit_end_flag);
  c_rx: cover property (@(posedge clk) rx_cap);
  c_tick: cover property (@(posedge clk) baud_tick);
endmodule : ssbg_top

// [sim/ssbg_peer.sv]
// far-side model: shift logic and remote peer producing transfer events
`timescale 1ns/10ps
module ssbg_peer
  import ssbg_pkg::*;
(
  // clock
  input  wire logic clk,
  // transfer events toward the block
  output ssbg_xfer_s xfer
);
  // remote rate is taken as matched to the divider within one percent
  initial xfer = '0;
  // one-cycle event; call just after an edge, never twice in one step
  task automatic pulse(input int which, input logic mpb);
    ssbg_xfer_s v;
    v = '0;
    v.tx_load = (which == 0);
    v.tx_last = (which == 1);
    v.rx_done = (which == 2);
    v.rx_mpb  = mpb;
    xfer <= v;
    @(posedge clk);
    // the bit line does not keep its last value after the character
    xfer <= {3'b000, ~mpb};
  endtask : pulse
endmodule : ssbg_peer

// [sim/ssbg_top_bench.sv]
// self-checking bench for the status flags, divider and baud generator
`timescale 1ns/10ps
module ssbg_top_bench
  import ssbg_pkg::*;
();
  logic        clk = 1'b0, rst = 1'b1, low_power = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, baud_tick, tx_mpb_out, tx_enable, rx_enable, irq;
  ssbg_xfer_s  xfer;
  int          n_errors = 0, check_count = 0, cycles = 0, seed = 84912, p, n;
  logic [7:0]  exp_q[$];
  logic [7:0]  d;
  logic [1:0]  sub_cnt = 2'h0;
  // source clocks per generator tick for each clock select; subclock pin rises every 4 cycles
  int          fac[5] = '{1, SSBG_PRE_16 + 1, SSBG_PRE_64 + 1, 4 * (SSBG_PRE_SUB + 1), 4};
  logic [2:0]  ckm[5] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h5};

  always #12.5 clk = ~clk;

  // subclock pin toggles off a free counter, so the subclock choice can be timed
  always @(posedge clk) sub_cnt <= sub_cnt + 2'h1;

  ssbg_peer u_peer (.clk(clk), .xfer(xfer));
  ssbg_top dut (.clk(clk), .rst(rst), .low_power(low_power), .sub_clk_pin(sub_cnt[1]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .xfer(xfer), .baud_tick(baud_tick),
    .tx_mpb_out(tx_mpb_out), .tx_enable(tx_enable), .rx_enable(rx_enable), .irq(irq));

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] s);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= v; sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'h1);
  endtask : wr

  // the expectation goes on the queue, the monitor compares it
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  // cycles between baud ticks, taken on the third tick so reloads settle
  task automatic period(output int c);
    repeat (3) begin
      c = 0;
      do begin @(posedge clk); c++; end while (baud_tick !== 1'b1 && c < 9000);
    end
  endtask : period

  // monitor: every read answer is matched against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("read data", {24'h0, exp_q.pop_front()}, rdat);
    end
  end

  // hang guard, well above the longest baud measurement
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SSBG_OFS_STATUS, 8'h84);
    rd(SSBG_OFS_DIVIDER, SSBG_DIV_RST);
    rd(4'h1, 8'h00);
    wr(SSBG_OFS_MODE, 32'h3);
    d = 8'($random(seed));
    wr(SSBG_OFS_DIVIDER, {24'h0, d});
    rd(SSBG_OFS_DIVIDER, d);
    // baud period per prescaler choice
    n = $random(seed) & 3;
    wr(SSBG_OFS_DIVIDER, n);
    for (int i = 0; i < 5; i++) begin
      wr(SSBG_OFS_MODE, {25'h0, ckm[i], 4'h1});
      period(p);
      chk("baud period", (n + 1) * fac[i], p);
    end
    // transmit flags
    wr(SSBG_OFS_MODE, 32'h7);
    chk("rx enable", 1, rx_enable);
    wr(SSBG_OFS_IRQ_ST, 32'h7);
    rd(SSBG_OFS_IRQ_ST, 8'h00);
    rd(SSBG_OFS_STATUS, 8'h84);
    wr(SSBG_OFS_STATUS, 32'h0);
    rd(SSBG_OFS_STATUS, 8'h00);
    u_peer.pulse(0, 1'b0);
    rd(SSBG_OFS_STATUS, 8'h80);
    u_peer.pulse(1, 1'b0);
    rd(SSBG_OFS_STATUS, 8'h84);
    bus(1'b1, SSBG_OFS_STATUS, 32'h80, 4'h3);
    rd(SSBG_OFS_STATUS, 8'h00);
    bus(1'b1, SSBG_OFS_MODE, 32'h206, 4'h3);
    rd(SSBG_OFS_STATUS, 8'h84);
    chk("irq", 1, irq);
    wr(SSBG_OFS_IRQ_ST, 32'h2);
    chk("irq", 0, irq);
    // received multiprocessor bit
    u_peer.pulse(2, 1'b1);
    rd(SSBG_OFS_STATUS, 8'h86);
    bus(1'b1, SSBG_OFS_MODE, 32'h406, 4'h3);
    chk("irq", 1, irq);
    wr(SSBG_OFS_STATUS, 32'h84);
    rd(SSBG_OFS_STATUS, 8'h86);
    wr(SSBG_OFS_MODE, 32'h4);
    rd(SSBG_OFS_STATUS, 8'h86);
    // transmitted multiprocessor bit
    wr(SSBG_OFS_MODE, 32'h5);
    chk("tx enable", 1, tx_enable);
    chk("rx enable", 0, rx_enable);
    wr(SSBG_OFS_STATUS, 32'h85);
    chk("tx mpb", 1, tx_mpb_out);
    wr(SSBG_OFS_STATUS, 32'h84);
    chk("tx mpb", 0, tx_mpb_out);
    // low-power entry reinitialises the registers
    low_power <= 1'b1;
    @(posedge clk);
    low_power <= 1'b0;
    @(posedge clk);
    rd(SSBG_OFS_DIVIDER, SSBG_DIV_RST);
    rd(SSBG_OFS_STATUS, 8'h84);
    test_done();
  end
endmodule : ssbg_top_bench
